// ### rtl/mac_filter.sv
// Transmit/receive enables, station address and multicast hash filter
//
// Contract
// - Transmit starts frames only while tx enabled
// - Receive takes frames only while rx enabled
// - Upper address: bits 47:32, ones reset
// - Lower address: bits 31:0, writable, ones
// - Octets one to six map to byte lanes
// - Multicast frames index a 64-bit hash table
// - Index top bit picks register, rest bit
// - Selected hash bit one accepts, else reject
// - Pass-all setting accepts every multicast frame
// - Hash registers read/write, reset to zero
`timescale 1ns/1ns
`include "mac_filter_regs.svh"
module mac_filter #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic pclk, // Clock, 50 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire mac_filter_pkg::tx_beat_s tx_in, // Frame byte to send
    input wire logic tx_in_valid, // Frame byte present
    output logic tx_in_ready, // Buffer has room
    output mac_filter_pkg::tx_beat_s phy_tx, // Byte to the PHY
    output logic phy_tx_valid, // Byte to the PHY valid
    input wire mac_filter_pkg::rx_beat_s rx_in, // Byte from the PHY
    input wire logic rx_valid, // Byte from the PHY valid
    output logic rx_done, // Frame finished, one cycle
    output mac_filter_pkg::verdict_s rx_verdict // Filter result
);
    import mac_filter_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_check
        $error("mac_filter: FIFO_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic hash_pick(input logic [31:0] upper,
                                       input logic [31:0] lower,
                                       input logic [5:0] idx);
        return idx[5] ? upper[idx[4:0]] : lower[idx[4:0]];
    endfunction : hash_pick

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic tx_path_on;
    logic rx_path_on;
    logic accept_every_group;
    logic [15:0] station_id_upper;
    logic [31:0] station_id_lower;
    logic [31:0] group_hash_upper;
    logic [31:0] group_hash_lower;
    logic [15:0] accept_count;
    logic tx_in_frame;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire access = psel & penable & ~pready;
    wire fire = psel & penable & pready & pwrite;
    wire hit_ctrl = paddr == `OFS_CONTROL;
    wire hit_upper = paddr == `OFS_STATION_UPPER;
    wire hit_lower = paddr == `OFS_STATION_LOWER;
    wire hit_hash_u = paddr == `OFS_HASH_UPPER;
    wire hit_hash_l = paddr == `OFS_HASH_LOWER;
    wire hit_stat = paddr == `OFS_STATUS;
    wire hit = hit_ctrl | hit_upper | hit_lower | hit_hash_u | hit_hash_l |
        hit_stat;

    wire [31:0] ctrl_word = (`WORD_ZERO |
        (32'(tx_path_on) << `CTRL_TX_BIT) |
        (32'(rx_path_on) << `CTRL_RX_BIT) |
        (32'(accept_every_group) << `CTRL_GROUP_BIT));
    wire [31:0] stat_word = (`WORD_ZERO |
        (32'(rx_verdict.idx) << `ST_IDX_LSB) |
        (32'(rx_verdict.accept) << `ST_ACCEPT_BIT) |
        (32'(rx_verdict.group) << `ST_GROUP_BIT) |
        (32'(tx_in_frame) << `ST_TX_BUSY_BIT) |
        (32'(accept_count) << `ST_COUNT_LSB));
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_word :
        hit_upper ? {16'h0000, station_id_upper} :
        hit_lower ? station_id_lower :
        hit_hash_u ? group_hash_upper :
        hit_hash_l ? group_hash_lower :
        hit_stat ? stat_word : `WORD_ZERO;
    wire [31:0] ctrl_new = merge(ctrl_word, pwdata, pstrb);
    wire [31:0] upper_new = merge({16'h0000, station_id_upper}, pwdata,
        pstrb);

    // One wait state: request seen, answer registered next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `WORD_ZERO;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            prdata <= (access & ~pwrite) ? rd_mux : `WORD_ZERO;
            pslverr <= access & ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_path_on <= 1'b0;
            rx_path_on <= 1'b0;
            accept_every_group <= 1'b0;
        end else if (fire & hit_ctrl) begin
            tx_path_on <= ctrl_new[`CTRL_TX_BIT];
            rx_path_on <= ctrl_new[`CTRL_RX_BIT];
            accept_every_group <= ctrl_new[`CTRL_GROUP_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            station_id_upper <= `UPPER_RESET;
            station_id_lower <= `LOWER_RESET;
            group_hash_upper <= `HASH_RESET;
            group_hash_lower <= `HASH_RESET;
        end else if (fire) begin
            if (hit_upper) begin
                station_id_upper <= upper_new[15:0];
            end
            if (hit_lower) begin
                station_id_lower <= merge(station_id_lower, pwdata,
                    pstrb);
            end
            if (hit_hash_u) begin
                group_hash_upper <= merge(group_hash_upper, pwdata,
                    pstrb);
            end
            if (hit_hash_l) begin
                group_hash_lower <= merge(group_hash_lower, pwdata,
                    pstrb);
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    tx_beat_s fifo_out;
    logic fifo_out_valid;
    // A frame already begun is finished even if transmit is switched off
    wire tx_pop = fifo_out_valid & (tx_path_on | tx_in_frame);

    beat_fifo #(
        .WIDTH($bits(tx_beat_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_data(tx_in),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(tx_pop)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_tx_valid <= 1'b0;
            phy_tx <= '0;
            tx_in_frame <= 1'b0;
        end else begin
            phy_tx_valid <= tx_pop;
            phy_tx <= tx_pop ? fifo_out : phy_tx;
            tx_in_frame <= tx_pop ? ~fifo_out.last : tx_in_frame;
        end
    end

    // ------------------------------------------------------------------
    // Receive filter
    // ------------------------------------------------------------------
    rx_state_e state;
    rx_state_e next_state;
    logic [2:0] byte_cnt;
    logic [39:0] dest;
    logic [31:0] crc;
    logic [31:0] crc_next;

    // Frames already under way when enabled are skipped whole
    wire start_ok = (state == RX_IDLE) & rx_valid & rx_in.first &
        ~rx_in.last & rx_path_on;
    wire in_dest = (state == RX_DEST) & rx_valid;
    wire at_decide = in_dest & (byte_cnt == `DEST_LAST);
    wire body_end = (state == RX_BODY) & rx_valid & rx_in.last;
    wire [31:0] crc_seed = (state == RX_IDLE) ? `CRC_INIT : crc;
    // Lane count is stale from the last frame until the first octet lands
    wire [2:0] lane = start_ok ? 3'h0 : byte_cnt;
    // Received octet k sits in byte lane k of the station vector
    wire [47:0] full_dest = {rx_in.data, dest};
    wire [47:0] station_vec = {station_id_upper, station_id_lower};
    wire [5:0] idx_now = crc_next[31:`HASH_IDX_LSB];
    wire group_now = full_dest[0];
    wire hash_hit = hash_pick(group_hash_upper, group_hash_lower,
        idx_now);
    wire accept_now = group_now ?
        (accept_every_group | hash_hit) :
        (full_dest == station_vec);

    crc32_byte u_crc (
        .crc_in(crc_seed),
        .data(rx_in.data),
        .crc_out(crc_next)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            RX_IDLE: begin
                if (start_ok) begin
                    next_state = RX_DEST;
                end
            end
            RX_DEST: begin
                if (rx_valid & rx_in.last) begin
                    next_state = RX_IDLE;
                end else if (at_decide) begin
                    next_state = RX_BODY;
                end
            end
            RX_BODY: begin
                if (body_end) begin
                    next_state = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RX_IDLE;
            byte_cnt <= 3'h0;
            dest <= '0;
            crc <= `CRC_INIT;
        end else begin
            state <= next_state;
            if (start_ok | (in_dest & ~at_decide)) begin
                dest[{lane, 3'h0} +: 8] <= rx_in.data;
                crc <= crc_next;
                byte_cnt <= start_ok ? `DEST_FIRST : 3'(byte_cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done <= 1'b0;
            rx_verdict <= '0;
            accept_count <= 16'h0000;
        end else begin
            rx_done <= body_end | (at_decide & rx_in.last);
            if (at_decide) begin
                rx_verdict <= '{accept: accept_now, group: group_now,
                                idx: idx_now};
            end
            if (rx_done & rx_verdict.accept) begin
                accept_count <= 16'(accept_count + 16'h0001);
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TX_GATED: assert property (
        $rose(phy_tx_valid) && !$past(tx_in_frame) |-> $past(tx_path_on))
        else $error("frame started while transmit disabled");
    AST_RX_GATED: assert property (
        state == RX_IDLE && rx_valid && !rx_path_on |=> state == RX_IDLE)
        else $error("frame taken while receive disabled");
    AST_UPPER_RSVD: assert property (
        access && !pwrite && hit_upper |=> pready && prdata[31:16] == 16'h0000)
        else $error("upper address reserved bits not zero");
    AST_LOWER_WRITE: assert property (
        fire && hit_lower && pstrb == 4'hF |=>
        station_id_lower == $past(pwdata))
        else $error("lower address write lost");
    AST_HASH_WRITE: assert property (
        fire && hit_hash_u && pstrb == 4'hF |=>
        group_hash_upper == $past(pwdata))
        else $error("upper hash write lost");
    AST_UNICAST: assert property (
        at_decide && !group_now && rx_in.data == station_id_upper[15:8] &&
        dest == {station_id_upper[7:0], station_id_lower}
        |=> rx_verdict.accept)
        else $error("own station address rejected");
    AST_HASH_SELECT: assert property (
        at_decide && group_now && !accept_every_group |=>
        rx_verdict.accept == ($past(idx_now[5]) ?
        $past(group_hash_upper[idx_now[4:0]]) :
        $past(group_hash_lower[idx_now[4:0]])))
        else $error("hash table bit not honoured");
    AST_PASS_ALL: assert property (
        at_decide && group_now && accept_every_group |=> rx_verdict.accept)
        else $error("multicast rejected with pass-all set");
    AST_HASH_INDEX: assert property (
        at_decide |=> rx_verdict.idx == $past(crc_next[31:26]))
        else $error("hash index not taken from crc");
    AST_APB_WAIT: assert property (
        access |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

    COV_GROUP_HIT: cover property (rx_done && rx_verdict.group &&
        rx_verdict.accept);
    COV_GROUP_MISS: cover property (rx_done && rx_verdict.group &&
        !rx_verdict.accept);
    COV_UNICAST: cover property (rx_done && !rx_verdict.group &&
        rx_verdict.accept);
    COV_TX_FULL: cover property (!tx_in_ready ##[1:20] phy_tx_valid);

endmodule : mac_filter

// ### rtl/mac_filter_regs.svh
// Register map, field positions, reset values and constants of the filter
`ifndef MAC_FILTER_REGS_SVH
`define MAC_FILTER_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 12'h100
`define OFS_STATION_UPPER 12'h104
`define OFS_STATION_LOWER 12'h108
`define OFS_HASH_UPPER 12'h10C
`define OFS_HASH_LOWER 12'h110
`define OFS_STATUS 12'h120

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define CTRL_RX_BIT 2
`define CTRL_TX_BIT 3
`define CTRL_GROUP_BIT 19
`define ST_IDX_LSB 0
`define ST_ACCEPT_BIT 8
`define ST_GROUP_BIT 9
`define ST_TX_BUSY_BIT 10
`define ST_COUNT_LSB 16

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define UPPER_RESET 16'hFFFF
`define LOWER_RESET 32'hFFFF_FFFF
`define HASH_RESET 32'h0000_0000
`define WORD_ZERO 32'h0000_0000
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320
`define HASH_IDX_LSB 26
`define DEST_LAST 3'h5
`define DEST_FIRST 3'h1

`endif

// ### rtl/mac_filter_pkg.sv
// Types shared by the station address and group filter block
package mac_filter_pkg;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } tx_beat_s;

    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } rx_beat_s;

    typedef struct packed {
        logic accept;
        logic group;
        logic [5:0] idx;
    } verdict_s;

    typedef enum logic [1:0] {RX_IDLE, RX_DEST, RX_BODY} rx_state_e;

endpackage : mac_filter_pkg

// ### rtl/beat_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module beat_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] in_data, // Fill data
    input wire logic in_valid, // Fill request
    output logic in_ready, // Room available (registered)
    output logic [WIDTH-1:0] out_data, // Head word
    output logic out_valid, // Head word present
    input wire logic out_ready // Drain accepts head
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("beat_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] next_count = AW'(1) == 0 ? count :
        count + (AW+1)'(push) - (AW+1)'(pop);

    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= next_count;
            // Registered so the port comes straight from a flop
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : beat_fifo

// ### rtl/crc32_byte.sv
// One byte step of the reflected CRC-32 used for the group hash
`timescale 1ns/1ns
`include "mac_filter_regs.svh"
module crc32_byte (
    input wire logic [31:0] crc_in, // Running remainder
    input wire logic [7:0] data, // Byte, least significant bit first
    output logic [31:0] crc_out // Remainder after the byte
);
    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ data[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end

endmodule : crc32_byte

// ### test/phy_model.sv
// Behavioural internal PHY: feeds receive frames, collects sent bytes
`timescale 1ns/1ns
module phy_model (
    input wire logic pclk, // Clock
    input wire mac_filter_pkg::tx_beat_s phy_tx, // Byte from the MAC
    input wire logic phy_tx_valid, // Byte from the MAC valid
    output mac_filter_pkg::rx_beat_s rx_in, // Byte to the MAC
    output logic rx_valid // Byte to the MAC valid
);
    import mac_filter_pkg::*;
    tx_beat_s txq[$];
    initial begin
        rx_in = '0;
        rx_valid = 1'b0;
    end
    always @(posedge pclk) begin
        if (phy_tx_valid === 1'b1) txq.push_back(phy_tx);
    end
    // Idle line shows inverted data, so a stale byte never looks current
    task automatic send(input logic [7:0] fr[$], input int gap);
        for (int i = 0; i < fr.size(); i++) begin
            @(posedge pclk);
            rx_in <= '{first: i == 0, last: i == fr.size() - 1, data: fr[i]};
            rx_valid <= 1'b1;
            repeat (gap) begin
                @(posedge pclk);
                rx_in.data <= ~fr[i];
                rx_valid <= 1'b0;
            end
        end
        @(posedge pclk);
        rx_in <= '{first: 1'b0, last: 1'b0, data: ~fr[fr.size() - 1]};
        rx_valid <= 1'b0;
    endtask : send
endmodule : phy_model

// ### test/tb_top.sv
// Self-checking bench for the station address and group filter
`timescale 1ns/1ns
module tb_top;
    import mac_filter_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    tx_beat_s tx_in, phy_tx;
    logic tx_in_valid, tx_in_ready, phy_tx_valid, rx_valid, rx_done;
    rx_beat_s rx_in;
    verdict_s rx_verdict;
    int mismatches = 0;
    int compares = 0;
    int done_cnt = 0;

    mac_filter #(.FIFO_DEPTH(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_in(tx_in), .tx_in_valid(tx_in_valid),
        .tx_in_ready(tx_in_ready), .phy_tx(phy_tx),
        .phy_tx_valid(phy_tx_valid), .rx_in(rx_in), .rx_valid(rx_valid),
        .rx_done(rx_done), .rx_verdict(rx_verdict));
    phy_model phy (.pclk(pclk), .phy_tx(phy_tx), .phy_tx_valid(phy_tx_valid),
        .rx_in(rx_in), .rx_valid(rx_valid));

    // ----------------------------------------
    // Clock, frame counter and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (rx_done === 1'b1) done_cnt++;
    end
    // Tests take well under a thousand cycles; this bound is far beyond that
    initial begin
        #1_000_000;
        mismatches++;
        stop_test();
    end

    // ----------------------------------------
    // Checking, bus and stream tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got,
                     exp);
        end
    endtask : chk

    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = 32'hffff_ffff;
        for (int i = 0; i < 48; i++) c = (c[0] ^ a[i]) ?
            (c >> 1) ^ 32'hedb8_8320 : c >> 1;
        return c[31:26];
    endfunction : hidx

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rdat,
                       output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        chk(n, 32'h0000_0002, "apb wait");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'b0, e}, 32'h0000_0000, "write error");
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp, "read data");
    endtask : rd

    task automatic rxf(input logic [47:0] dst, input int gap, input logic ex,
                       input logic [7:0] ev, input logic [7:0] m);
        logic [7:0] q[$];
        int d0;
        d0 = done_cnt;
        for (int i = 0; i < 6; i++) q.push_back(dst[8*i+:8]);
        q.push_back(8'h5a);
        q.push_back(8'ha5);
        phy.send(q, gap);
        repeat (4) @(posedge pclk);
        chk(32'(done_cnt - d0), {31'b0, ex}, "frame end");
        if (ex) chk({24'b0, rx_verdict & m}, {24'b0, ev & m}, "verdict");
    endtask : rxf

    task automatic push(input int n, input int lim, output logic ok);
        int c;
        @(posedge pclk);
        tx_in <= '{last: n == 5, data: 8'h10 + 8'(n)};
        tx_in_valid <= 1'b1;
        ok = 1'b0;
        for (c = 0; c < lim && !ok; c++) begin
            @(posedge pclk);
            ok = tx_in_ready === 1'b1;
        end
        tx_in_valid <= 1'b0;
    endtask : push

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [31:0] v, r, hu, hl;
        logic [47:0] dst;
        logic [5:0] t;
        logic ok;
        int n, k;
        void'($urandom(32'h59b2));
        {psel, penable, pwrite, tx_in_valid} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        tx_in = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h100, 32'h0000_0000);
        rd(12'h104, 32'h0000_ffff);
        rd(12'h108, 32'hffff_ffff);
        rd(12'h10c, 32'h0000_0000);
        rd(12'h110, 32'h0000_0000);
        rd(12'h120, 32'h0000_0000);
        for (n = 0; n < 4; n++) begin
            v = $urandom;
            wr(12'h104, v);
            rd(12'h104, {16'h0000, v[15:0]});
            wr(12'h108, ~v);
            rd(12'h108, ~v);
            wr(12'h10c, v ^ 32'h5a5a_5a5a);
            rd(12'h10c, v ^ 32'h5a5a_5a5a);
            wr(12'h110, {v[15:0], v[31:16]});
            rd(12'h110, {v[15:0], v[31:16]});
        end
        apb(1'b1, 12'h1f0, v, r, ok);
        chk({31'b0, ok}, 32'h0000_0001, "unmapped write");
        apb(1'b0, 12'h1f0, v, r, ok);
        chk({31'b0, ok}, 32'h0000_0001, "unmapped read");
        chk(r, 32'h0000_0000, "unmapped data");
        $display("Test registers done");
        dst = {16'($urandom), 32'($urandom)};
        dst[0] = 1'b0;
        wr(12'h108, dst[31:0]);
        wr(12'h104, {16'h0000, dst[47:32]});
        wr(12'h100, 32'h0000_0004);
        rxf(dst, 0, 1'b1, 8'h80, 8'hc0);
        k = $urandom_range(5);
        rxf(dst ^ (48'h2 << (8 * k)), 1, 1'b1, 8'h00, 8'hc0);
        wr(12'h100, 32'h0000_0000);
        rxf(dst, 0, 1'b0, 8'h80, 8'hc0);
        $display("Test station match done");
        wr(12'h100, 32'h0000_0004);
        for (n = 0; n < 5; n++) begin
            // Table corners first: both ends of each hash register
            t = (n < 4) ? {n[1], {5{n[0]}}} : 6'($urandom);
            k = 0;
            do begin
                dst = {16'($urandom), 32'($urandom)} | 48'h1;
                k++;
            end while (hidx(dst) != t && k < 5000);
            hu = t[5] ? 32'h0000_0001 << t[4:0] : 32'h0000_0000;
            hl = t[5] ? 32'h0000_0000 : 32'h0000_0001 << t[4:0];
            wr(12'h10c, hu);
            wr(12'h110, hl);
            rxf(dst, n % 2, 1'b1, {2'b11, t}, 8'hff);
            wr(12'h10c, ~hu);
            wr(12'h110, ~hl);
            rxf(dst, 0, 1'b1, {2'b01, t}, 8'hff);
            wr(12'h100, 32'h0008_0004);
            rxf(dst, 1, 1'b1, {2'b11, t}, 8'hff);
            wr(12'h100, 32'h0000_0004);
        end
        $display("Test group hash done");
        // Transmit off acts as a stalled far side: the fifth byte must wait
        k = 0;
        for (n = 0; n < 5; n++) begin
            push(n, 8, ok);
            k += ok;
        end
        chk(k, 32'h0000_0004, "buffered bytes");
        chk(phy.txq.size(), 32'h0000_0000, "sent while off");
        wr(12'h100, 32'h0000_0008);
        for (n = k; n < 6; n++) push(n, 50, ok);
        repeat (20) @(posedge pclk);
        chk(phy.txq.size(), 32'h0000_0006, "sent count");
        for (n = 0; n < 6 && n < phy.txq.size(); n++) chk({23'b0, phy.txq[n]},
            {23'b0, n == 5, 8'h10 + 8'(n)}, "tx byte");
        $display("Test transmit done");
        stop_test();
    end
endmodule : tb_top
